// ===== hdl/bcrtc_pkg.sv
// constants and register map of the bcd calendar clock with backup words
package bcrtc_pkg;
    localparam logic [7:0] A_TIME = 8'h00;
    localparam logic [7:0] A_DATE = 8'h04;
    localparam logic [7:0] A_CTRL = 8'h08;
    localparam logic [7:0] A_SUBSEC = 8'h0C;
    localparam logic [7:0] A_PRESC = 8'h10;
    localparam logic [7:0] A_WUT = 8'h14;
    localparam logic [7:0] A_ALRA = 8'h18;
    localparam logic [7:0] A_ALRB = 8'h1C;
    localparam logic [7:0] A_SHIFT = 8'h20;
    localparam logic [7:0] A_CALIB = 8'h24;
    localparam logic [7:0] A_TAMPF = 8'h28;
    localparam logic [7:0] A_TSTIME = 8'h2C;
    localparam logic [7:0] A_TSDATE = 8'h30;
    localparam logic [7:0] A_STAT = 8'h34;
    localparam logic [7:0] A_CLR = 8'h38;
    localparam logic [7:0] A_IEN = 8'h3C;
    localparam logic [7:0] A_BKP0 = 8'h40;
    localparam int NBKP = 5;
    localparam int NST = 6;
    localparam int FL_ALA = 0;
    localparam int FL_ALB = 1;
    localparam int FL_WU = 2;
    localparam int FL_TS = 3;
    localparam int FL_TP0 = 4;
    localparam logic [6:0] APRE_RST = 7'h7F;
    localparam logic [14:0] SPRE_RST = 15'h00FF;
    localparam logic [7:0] REF50_LAST = 8'h31;
    localparam logic [7:0] REF60_LAST = 8'h3B;
    localparam logic [10:0] CAL_INS_PER = 11'h000;
endpackage

// ===== hdl/bcrtc_top.sv
// bcd calendar clock with alarms, wakeup, tamper, timestamp and backup words
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module bcrtc_top (
    // ahb-lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // power-domain reset, active low
    input wire logic pwr_rst_n,
    // clock sources and pins
    input wire logic [3:0] src_clk,
    input wire logic ref_in,
    input wire logic ts_in,
    input wire logic [1:0] tamp_in,
    // interrupt and dedicated lines
    output logic irq,
    output logic ext_line_alarm,
    output logic ext_line_wakeup,
    output logic ext_line_tamp_ts
);
    import bcrtc_pkg::*;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic leap(input logic [7:0] y);
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02: last_day = leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default: last_day = 8'h31;
        endcase
    endfunction

    function automatic logic alr_hit(input logic [31:0] a, input logic [7:0] s, input logic [7:0] mi,
                                     input logic [7:0] h, input logic p, input logic [7:0] d);
        alr_hit = (a[7] || a[6:0] == s[6:0]) && (a[15] || a[14:8] == mi[6:0]) &&
                  (a[23] || ({a[22], a[21:16]} == {p, h[5:0]})) && (a[31] || a[29:24] == d[5:0]);
    endfunction

    // bus phases
    logic dp_we_r;
    logic [7:0] dp_addr_r;
    logic [31:0] rd_nxt;
    wire logic ap_go = hsel && htrans[1] && hready;
    wire logic wr = dp_we_r;

    function automatic logic wr_at(input logic [7:0] a, input logic we, input logic [7:0] da);
        wr_at = we && (da == a);
    endfunction

    // configuration
    logic fmt12_r, wu_en_r, ref_en_r, ref60_r, ts_en_r;
    logic [1:0] clksel_r, alr_en_r, tamp_en_r;
    logic [2:0] wusel_r, tflt_r;
    logic [6:0] apre_r;
    logic [14:0] spre_r, subfs_r;
    logic [15:0] wut_r;
    logic [31:0] alr_r [2];
    logic calp_r, shift_pend_r, add1s_r;
    logic [8:0] calm_r;
    logic [NST-1:0] flag_r, ien_r, flag_set;
    logic [31:0] bkp_r [NBKP];

    // calendar
    logic [7:0] sec_r, min_r, hour_r, date_r, mon_r, year_r;
    logic [2:0] wday_r;
    logic pm_r;
    logic [31:0] ts_time_r, ts_date_r;
    wire logic [31:0] time_w = {9'h000, pm_r, hour_r[5:0], 1'b0, min_r[6:0], 1'b0, sec_r[6:0]};
    wire logic [31:0] date_w = {8'h00, year_r, wday_r, mon_r[4:0], 2'b00, date_r[5:0]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_we_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dp_we_r <= ap_go && hwrite;
            dp_addr_r <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (ap_go && !hwrite) begin
                hrdata <= rd_nxt;
            end
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (haddr[7:0])
            A_TIME: rd_nxt = time_w;
            A_DATE: rd_nxt = date_w;
            A_CTRL: rd_nxt = {18'h00000, ts_en_r, ref60_r, tamp_en_r, ref_en_r, wusel_r,
                              alr_en_r, wu_en_r, clksel_r, fmt12_r};
            A_PRESC: rd_nxt = {9'h000, apre_r, 1'b0, spre_r};
            A_WUT: rd_nxt = {16'h0000, wut_r};
            A_ALRA: rd_nxt = alr_r[0];
            A_ALRB: rd_nxt = alr_r[1];
            A_SHIFT: rd_nxt = {add1s_r, 15'h0000, shift_pend_r, subfs_r};
            A_CALIB: rd_nxt = {16'h0000, calp_r, 6'h00, calm_r};
            A_TAMPF: rd_nxt = {29'h0000_0000, tflt_r};
            A_TSTIME: rd_nxt = ts_time_r;
            A_TSDATE: rd_nxt = ts_date_r;
            A_STAT: rd_nxt = {{(32-NST){1'b0}}, flag_r};
            A_IEN: rd_nxt = {{(32-NST){1'b0}}, ien_r};
            default: rd_nxt = 32'h0000_0000;
        endcase
        for (int k = 0; k < NBKP; k++) begin
            if (haddr[7:0] == A_BKP0 + 8'(4 * k)) begin
                rd_nxt = bkp_r[k];
            end
        end
    end

    // backup words on power reset only
    always_ff @(posedge hclk or negedge pwr_rst_n) begin
        if (!pwr_rst_n) begin
            for (int k = 0; k < NBKP; k++) begin
                bkp_r[k] <= 32'h0000_0000;
            end
        end else begin
            for (int k = 0; k < NBKP; k++) begin
                if (wr_at(A_BKP0 + 8'(4 * k), wr, dp_addr_r)) begin
                    bkp_r[k] <= hwdata;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {ts_en_r, ref60_r, tamp_en_r, ref_en_r, wusel_r, alr_en_r, wu_en_r, clksel_r, fmt12_r} <= 14'h0000;
            apre_r <= APRE_RST;
            spre_r <= SPRE_RST;
            wut_r <= 16'h0000;
            alr_r[0] <= 32'h0000_0000;
            alr_r[1] <= 32'h0000_0000;
            calp_r <= 1'b0;
            calm_r <= 9'h000;
            tflt_r <= 3'h0;
            ien_r <= '0;
        end else begin
            if (wr_at(A_CTRL, wr, dp_addr_r)) begin
                {ts_en_r, ref60_r, tamp_en_r, ref_en_r, wusel_r, alr_en_r, wu_en_r, clksel_r, fmt12_r} <= hwdata[13:0];
            end
            if (wr_at(A_PRESC, wr, dp_addr_r)) begin
                apre_r <= hwdata[22:16];
                spre_r <= hwdata[14:0];
            end
            if (wr_at(A_WUT, wr, dp_addr_r)) begin
                wut_r <= hwdata[15:0];
            end
            if (wr_at(A_ALRA, wr, dp_addr_r)) begin
                alr_r[0] <= hwdata;
            end
            if (wr_at(A_ALRB, wr, dp_addr_r)) begin
                alr_r[1] <= hwdata;
            end
            if (wr_at(A_CALIB, wr, dp_addr_r)) begin
                calp_r <= hwdata[15];
                calm_r <= hwdata[8:0];
            end
            if (wr_at(A_TAMPF, wr, dp_addr_r)) begin
                tflt_r <= hwdata[2:0];
            end
            if (wr_at(A_IEN, wr, dp_addr_r)) begin
                ien_r <= hwdata[NST-1:0];
            end
        end
    end

    logic src_q_r;
    wire logic src_now = src_clk[clksel_r];
    wire logic rtc_pulse = src_now && !src_q_r;

    // calibration: mask calm pulses, insert 512 per window
    logic [19:0] cal_cnt_r;
    wire logic cal_mask = (cal_cnt_r[19:9] == 11'h000) && (cal_cnt_r[8:0] < calm_r);
    wire logic cal_ins = calp_r && (cal_cnt_r[10:0] == CAL_INS_PER);
    wire logic [1:0] step = rtc_pulse ? ({1'b0, !cal_mask} + {1'b0, cal_ins}) : 2'b00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q_r <= 1'b0;
            cal_cnt_r <= 20'h00000;
        end else begin
            src_q_r <= src_now;
            if (rtc_pulse) begin
                cal_cnt_r <= cal_cnt_r + 20'h00001;
            end
        end
    end

    logic [6:0] apre_cnt_r;
    logic [14:0] ss_r;
    wire logic [7:0] apre_sum = {1'b0, apre_cnt_r} + {6'h00, step};
    wire logic ck_apre = apre_sum > {1'b0, apre_r};
    logic [7:0] ref_cnt_r;
    logic ref_q_r;
    wire logic ref_edge = ref_in && !ref_q_r;
    wire logic ref_sec = ref_en_r && ref_edge && (ref_cnt_r == (ref60_r ? REF60_LAST : REF50_LAST));
    logic ss_sec;
    logic sec_tick;

    always_comb begin
        ss_sec = ck_apre && !shift_pend_r && (ss_r == 15'h0000);
        sec_tick = ref_en_r ? ref_sec : (ss_sec || (ck_apre && shift_pend_r && add1s_r));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            apre_cnt_r <= 7'h00;
            ss_r <= SPRE_RST;
            ref_cnt_r <= 8'h00;
            ref_q_r <= 1'b0;
        end else begin
            ref_q_r <= ref_in;
            apre_cnt_r <= ck_apre ? 7'(apre_sum - {1'b0, apre_r} - 8'h01) : apre_sum[6:0];
            if (ref_edge) begin
                ref_cnt_r <= ref_sec ? 8'h00 : ref_cnt_r + 8'h01;
            end
            if (ref_sec) begin
                ss_r <= spre_r;
            end else if (ck_apre && shift_pend_r) begin
                // shift delays the count in flight
                ss_r <= ss_r + subfs_r;
            end else if (ck_apre) begin
                ss_r <= (ss_r == 15'h0000) ? spre_r : ss_r - 15'h0001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_pend_r <= 1'b0;
            add1s_r <= 1'b0;
            subfs_r <= 15'h0000;
        end else if (wr_at(A_SHIFT, wr, dp_addr_r) && !shift_pend_r) begin
            shift_pend_r <= 1'b1;
            add1s_r <= hwdata[31];
            subfs_r <= hwdata[14:0];
        end else if (ck_apre) begin
            shift_pend_r <= 1'b0;
        end
    end

    // carry chain
    wire logic sec_c = sec_tick && sec_r == 8'h59;
    wire logic min_c = sec_c && min_r == 8'h59;
    wire logic day_c = min_c && (fmt12_r ? (hour_r == 8'h11 && pm_r) : hour_r == 8'h23);
    wire logic mon_c = day_c && date_r == last_day(mon_r, year_r);
    wire logic yr_c = mon_c && mon_r == 8'h12;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {sec_r, min_r, hour_r, year_r} <= 32'h0000_0000;
            pm_r <= 1'b0;
            date_r <= 8'h01;
            mon_r <= 8'h01;
            wday_r <= 3'h1;
        end else if (wr_at(A_TIME, wr, dp_addr_r)) begin
            sec_r <= {1'b0, hwdata[6:0]};
            min_r <= {1'b0, hwdata[14:8]};
            hour_r <= {2'b00, hwdata[21:16]};
            pm_r <= hwdata[22];
        end else if (wr_at(A_DATE, wr, dp_addr_r)) begin
            date_r <= {2'b00, hwdata[5:0]};
            mon_r <= {3'b000, hwdata[12:8]};
            wday_r <= hwdata[15:13];
            year_r <= hwdata[23:16];
        end else if (sec_tick) begin
            sec_r <= sec_c ? 8'h00 : bcd_inc(sec_r);
            if (sec_c) begin
                min_r <= min_c ? 8'h00 : bcd_inc(min_r);
            end
            if (min_c && fmt12_r) begin
                hour_r <= (hour_r == 8'h12) ? 8'h01 : bcd_inc(hour_r);
                pm_r <= (hour_r == 8'h11) ? !pm_r : pm_r;
            end else if (min_c) begin
                hour_r <= day_c ? 8'h00 : bcd_inc(hour_r);
            end
            if (day_c) begin
                date_r <= mon_c ? 8'h01 : bcd_inc(date_r);
                wday_r <= (wday_r == 3'h7) ? 3'h1 : wday_r + 3'h1;
            end
            if (mon_c) begin
                mon_r <= yr_c ? 8'h01 : bcd_inc(mon_r);
            end
            if (yr_c) begin
                year_r <= (year_r == 8'h99) ? 8'h00 : bcd_inc(year_r);
            end
        end
    end

    logic [1:0] alr_q_r, alr_now;
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            alr_now[k] = alr_en_r[k] && alr_hit(alr_r[k], sec_r, min_r, hour_r, pm_r, date_r);
        end
    end

    logic [3:0] wu_pre_r;
    logic [15:0] wu_cnt_r;
    wire logic [3:0] wu_mask = 4'hF >> wusel_r[1:0];
    wire logic wu_clk = wusel_r[2] ? sec_tick : (rtc_pulse && ((wu_pre_r | ~wu_mask) == 4'hF));
    wire logic wu_fire = wu_en_r && wu_clk && (wu_cnt_r == 16'h0000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alr_q_r <= 2'b00;
            wu_pre_r <= 4'h0;
            wu_cnt_r <= 16'h0000;
        end else begin
            alr_q_r <= alr_now;
            if (rtc_pulse) begin
                wu_pre_r <= wu_pre_r + 4'h1;
            end
            if (!wu_en_r) begin
                wu_cnt_r <= wut_r;
            end else if (wu_clk) begin
                wu_cnt_r <= (wu_cnt_r == 16'h0000) ? wut_r : wu_cnt_r - 16'h0001;
            end
        end
    end

    wire logic [1:0] tamp_ev;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tamp
            logic [2:0] run_r;
            logic lvl_r;
            wire logic full = run_r >= tflt_r;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    run_r <= 3'h0;
                    lvl_r <= 1'b0;
                end else begin
                    run_r <= !tamp_in[gi] ? 3'h0 : (full ? run_r : run_r + 3'h1);
                    lvl_r <= tamp_in[gi] && full;
                end
            end
            assign tamp_ev[gi] = tamp_en_r[gi] && tamp_in[gi] && full && !lvl_r;
        end
    endgenerate

    // timestamp capture from pin or tamper
    logic ts_q_r;
    wire logic ts_ev = (ts_en_r && ts_in && !ts_q_r) || (|tamp_ev);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ts_q_r <= 1'b0;
            ts_time_r <= 32'h0000_0000;
            ts_date_r <= 32'h0000_0000;
        end else begin
            ts_q_r <= ts_in;
            if (ts_ev) begin
                ts_time_r <= time_w;
                ts_date_r <= date_w;
            end
        end
    end

    // sticky flags, set wins over clear
    always_comb begin
        flag_set = '0;
        flag_set[FL_ALA] = alr_now[0] && !alr_q_r[0];
        flag_set[FL_ALB] = alr_now[1] && !alr_q_r[1];
        flag_set[FL_WU] = wu_fire;
        flag_set[FL_TS] = ts_ev;
        flag_set[FL_TP0] = tamp_ev[0];
        flag_set[FL_TP0 + 1] = tamp_ev[1];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= '0;
        end else begin
            flag_r <= (flag_r & ~(wr_at(A_CLR, wr, dp_addr_r) ? hwdata[NST-1:0] : '0)) | flag_set;
        end
    end

    // dedicated event lines and gated interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
            ext_line_alarm <= 1'b0;
            ext_line_wakeup <= 1'b0;
            ext_line_tamp_ts <= 1'b0;
        end else begin
            irq <= |(flag_r & ien_r);
            ext_line_alarm <= flag_r[FL_ALA] || flag_r[FL_ALB];
            ext_line_wakeup <= flag_r[FL_WU];
            ext_line_tamp_ts <= flag_r[FL_TS] || flag_r[FL_TP0] || flag_r[FL_TP0 + 1];
        end
    end

    AST_BKP_HOLD: assert property (@(posedge hclk) disable iff (!pwr_rst_n)
        !wr_at(A_BKP0, wr, dp_addr_r) |=> $stable(bkp_r[0])) else $error("backup word changed");
    AST_SEC_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
        sec_c && !wr |=> sec_r == 8'h00 && min_r != $past(min_r)) else $error("seconds wrap");
    AST_H12: assert property (@(posedge hclk) disable iff (!hresetn)
        min_c && fmt12_r && hour_r == 8'h12 && !wr |=> hour_r == 8'h01) else $error("12h wrap");
    AST_FEB: assert property (@(posedge hclk) disable iff (!hresetn)
        day_c && mon_r == 8'h02 && date_r == 8'h28 && !leap(year_r) && !wr |=> date_r == 8'h01 && mon_r == 8'h03)
        else $error("february end");
    AST_WU: assert property (@(posedge hclk) disable iff (!hresetn)
        wu_fire |=> flag_r[FL_WU] ##1 ext_line_wakeup) else $error("wakeup flag");
    AST_TS: assert property (@(posedge hclk) disable iff (!hresetn)
        ts_ev |=> ts_time_r == $past(time_w) && ts_date_r == $past(date_w)) else $error("timestamp copy");
    AST_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        flag_r[FL_TS] && !wr_at(A_CLR, wr, dp_addr_r) |=> flag_r[FL_TS]) else $error("flag lost");
    AST_SHIFT: assert property (@(posedge hclk) disable iff (!hresetn)
        ck_apre && shift_pend_r && !ref_sec |=> ss_r == 15'($past(ss_r) + $past(subfs_r)) && !shift_pend_r)
        else $error("shift not applied");
    AST_TAMP: assert property (@(posedge hclk) disable iff (!hresetn)
        tamp_ev[0] |=> flag_r[FL_TP0] && flag_r[FL_TS] ##1 ext_line_tamp_ts) else $error("tamper flags");
endmodule

// ===== tb/tb.sv
// self-checking bench for the bcd calendar clock block
`timescale 1ns/1ps
module tb;
    import bcrtc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pwr_rst_n, ref_in, ts_in;
    logic irq, ext_line_alarm, ext_line_wakeup, ext_line_tamp_ts, rd_dp;
    logic [31:0] haddr, hwdata, hrdata, exp_w;
    logic [1:0] htrans, tamp_in;
    logic [2:0] hsize;
    logic [3:0] src_clk, src_sel;
    logic [31:0] notes[$];
    logic [31:0] bkp [NBKP];
    int num_errors, comparisons, cycles;
    // ctrl, time in, date in, time out, date out
    logic [31:0] cal [8][5] = '{
        '{32'h00000000, 32'h00235959, 32'h00012228, 32'h00000000, 32'h00014301},
        '{32'h00000000, 32'h00235959, 32'h00042228, 32'h00000000, 32'h00044229},
        '{32'h00000000, 32'h00235959, 32'h00042229, 32'h00000000, 32'h00044301},
        '{32'h00000000, 32'h00235959, 32'h00012430, 32'h00000000, 32'h00014501},
        '{32'h00000000, 32'h00235959, 32'h00012131, 32'h00000000, 32'h00014201},
        '{32'h00000000, 32'h00235959, 32'h00993231, 32'h00000000, 32'h00004101},
        '{32'h00000001, 32'h00115959, 32'h00012210, 32'h00520000, 32'h00012210},
        '{32'h00000001, 32'h00125959, 32'h00012210, 32'h00010000, 32'h00012210}};

    assign hready = hreadyout;

    bcrtc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pwr_rst_n(pwr_rst_n), .src_clk(src_clk), .ref_in(ref_in),
        .ts_in(ts_in), .tamp_in(tamp_in), .irq(irq), .ext_line_alarm(ext_line_alarm),
        .ext_line_wakeup(ext_line_wakeup), .ext_line_tamp_ts(ext_line_tamp_ts));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task check(input logic [31:0] seen, input logic [31:0] expd);
        comparisons++;
        if (seen !== expd) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    task results;
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one single-word transfer; a read leaves its expected word in the queue
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        if (!w) begin
            notes.push_back(d);
        end
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= w ? d : 32'h00000000;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    // whole slow-clock pulses, well below half the bus clock rate
    task pulse(input int n);
        repeat (n) begin
            repeat (4) @(posedge hclk);
            src_clk <= src_sel;
            repeat (4) @(posedge hclk);
            src_clk <= 4'h0;
        end
        repeat (6) @(posedge hclk);
        #1;
    endtask

    // rising edges on the reference input
    task refp(input int n);
        repeat (n) begin
            repeat (2) @(posedge hclk);
            ref_in <= 1'b1;
            repeat (2) @(posedge hclk);
            ref_in <= 1'b0;
        end
        repeat (4) @(posedge hclk);
    endtask

    always @(posedge hclk) begin
        if (rd_dp === 1'b1 && hready === 1'b1) begin
            exp_w = notes.pop_front();
            check(hrdata, exp_w);
            check(hresp, 32'h0);
        end
        rd_dp <= hresetn && hsel && htrans[1] && !hwrite && hready;
    end

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        hresetn = 1'b0;
        pwr_rst_n = 1'b0;
        src_clk = 4'h0;
        src_sel = 4'h1;
        ref_in = 1'b0;
        ts_in = 1'b0;
        tamp_in = 2'h0;
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        void'($urandom(4280));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        pwr_rst_n <= 1'b1;
        for (int i = 0; i < NBKP; i++) begin
            bkp[i] = $urandom();
            xfer(1'b1, A_BKP0 + 8'(4 * i), bkp[i]);
        end
        for (int i = 0; i < NBKP; i++) xfer(1'b0, A_BKP0 + 8'(4 * i), bkp[i]);
        xfer(1'b0, 8'hFC, 32'h00000000);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < NBKP; i++) xfer(1'b0, A_BKP0 + 8'(4 * i), bkp[i]);
        @(posedge hclk);
        pwr_rst_n <= 1'b0;
        repeat (3) @(posedge hclk);
        pwr_rst_n <= 1'b1;
        for (int i = 0; i < NBKP; i++) xfer(1'b0, A_BKP0 + 8'(4 * i), 32'h00000000);
        // sync counter first runs out its reset reload; four pulses masked
        xfer(1'b1, A_PRESC, 32'h00010001);
        xfer(1'b1, A_CALIB, 32'h00000004);
        pulse(512);
        xfer(1'b0, A_TIME, 32'h00000000);
        pulse(4);
        xfer(1'b0, A_TIME, 32'h00000001);
        // calendar rollovers, one second tick each
        for (int k = 0; k < 8; k++) begin
            xfer(1'b1, A_CTRL, cal[k][0]);
            xfer(1'b1, A_TIME, cal[k][1]);
            xfer(1'b1, A_DATE, cal[k][2]);
            pulse(4);
            xfer(1'b0, A_TIME, cal[k][3]);
            xfer(1'b0, A_DATE, cal[k][4]);
        end
        // only the selected source counts; shift adds a second in flight
        xfer(1'b1, A_CTRL, 32'h00000004);
        xfer(1'b1, A_TIME, 32'h00000000);
        pulse(4);
        xfer(1'b0, A_TIME, 32'h00000000);
        src_sel <= 4'h4;
        pulse(4);
        xfer(1'b0, A_TIME, 32'h00000001);
        xfer(1'b1, A_SHIFT, 32'h80000001);
        pulse(2);
        xfer(1'b0, A_TIME, 32'h00000002);
        pulse(6);
        xfer(1'b0, A_TIME, 32'h00000003);
        src_sel <= 4'h1;
        // alarm a on seconds only, then mask and clear
        xfer(1'b1, A_CTRL, 32'h00000010);
        xfer(1'b1, A_ALRA, 32'h80808001);
        xfer(1'b1, A_IEN, 32'h00000001);
        xfer(1'b1, A_TIME, 32'h00000000);
        pulse(4);
        check(irq, 32'h1);
        check(ext_line_alarm, 32'h1);
        xfer(1'b1, A_IEN, 32'h00000000);
        xfer(1'b0, A_STAT, 32'h00000001);
        #1;
        check(irq, 32'h0);
        xfer(1'b1, A_CLR, 32'h00000001);
        xfer(1'b0, A_STAT, 32'h00000000);
        // wakeup at 1 Hz with reload zero
        xfer(1'b1, A_WUT, 32'h00000000);
        xfer(1'b1, A_CTRL, 32'h00000108);
        pulse(8);
        check(ext_line_wakeup, 32'h1);
        xfer(1'b0, A_STAT, 32'h00000004);
        xfer(1'b1, A_CTRL, 32'h00000000);
        xfer(1'b1, A_CLR, 32'h0000003F);
        // tamper 0 with no filter also takes a timestamp
        xfer(1'b1, A_TAMPF, 32'h00000000);
        xfer(1'b1, A_TIME, 32'h00123456);
        xfer(1'b1, A_DATE, 32'h00014301);
        xfer(1'b1, A_CTRL, 32'h00000400);
        tamp_in <= 2'h1;
        pulse(0);
        check(ext_line_tamp_ts, 32'h1);
        xfer(1'b0, A_STAT, 32'h00000018);
        xfer(1'b0, A_TSTIME, 32'h00123456);
        tamp_in <= 2'h0;
        xfer(1'b1, A_CTRL, 32'h00000000);
        xfer(1'b1, A_CLR, 32'h0000003F);
        xfer(1'b0, A_STAT, 32'h00000000);
        // timestamp pin edge
        xfer(1'b1, A_CTRL, 32'h00002000);
        ts_in <= 1'b1;
        pulse(0);
        check(ext_line_tamp_ts, 32'h1);
        xfer(1'b0, A_STAT, 32'h00000008);
        xfer(1'b0, A_TSDATE, 32'h00014301);
        ts_in <= 1'b0;
        // fiftieth reference edge makes the second
        xfer(1'b1, A_CTRL, 32'h00000200);
        xfer(1'b1, A_TIME, 32'h00000000);
        refp(49);
        xfer(1'b0, A_TIME, 32'h00000000);
        refp(1);
        xfer(1'b0, A_TIME, 32'h00000001);
        repeat (2) @(posedge hclk);
        results();
    end
endmodule
